// ===== src/tec_param_core.v
// Parameter access, state control and link options of the TEC block
`timescale 1ns/1ps
`include "tec_param_map.vh"

module tec_param_core
#(
   parameter SAVE_CYCLES = `SAVE_MS * (`CLK_HZ / 1000)
)
(
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        cmd_valid,
   output wire        cmd_ready,
   input  wire [7:0]  cmd_type,
   input  wire [15:0] cmd_param,
   input  wire [15:0] cmd_value,
   output wire        tx_valid,
   input  wire        tx_ready,
   output reg  [7:0]  tx_data,
   input  wire [15:0] tec_current_in,
   input  wire [15:0] tec_voltage_in,
   input  wire        overtemp_warn_pin,
   input  wire        overtemp_prot_pin,
   output reg         tec_started,
   output reg         setpoint_internal,
   output reg         enable_internal,
   output wire        continuous_output,
   output wire        long_pulse_output,
   output reg  [15:0] freq_value,
   output reg  [15:0] duration_value,
   output reg  [15:0] tec_current_limit,
   output reg  [15:0] tec_calibration,
   output reg  [15:0] thermistor_beta,
   output wire [15:0] serial_link_options,
   output reg  [2:0]  baud_sel,
   output wire        binary_mode,
   output wire        checksum_on,
   output reg         save_start,
   output wire        save_busy
);

   // Response engine states
   localparam S_IDLE = 1'b0;
   localparam S_SEND = 1'b1;

   localparam [15:0] DUR_MIN =
      `DUR_MIN_MS * `UNITS_PER_MS;
   localparam [16:0] DUR_CAP =
      `DUR_CAP_MS * `UNITS_PER_MS;
   localparam [31:0] SAVE_END  = SAVE_CYCLES - 1;

   // Clamp a value into [lo, hi]
   function [15:0] clamp;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         if (v < lo)
            clamp = lo;
         else if (v > hi)
            clamp = hi;
         else
            clamp = v;
      end
   endfunction

   // Longest duration for a frequency, 0.1 ms units
   function [15:0] dur_limit;
      input [15:0] f;
      reg   [16:0] per;
      begin
         per = DUR_CAP + DUR_MIN;
         if (f != 16'h0000)
            per = 17'd100000 / {1'b0, f};
         if (per <= {1'b0, DUR_MIN} + {1'b0, DUR_MIN})
            dur_limit = DUR_MIN;
         else if (per - {1'b0, DUR_MIN} > DUR_CAP)
            dur_limit = DUR_CAP[15:0];
         else
            dur_limit = per[15:0] - DUR_MIN;
      end
   endfunction

   // ASCII hex digit of a nibble
   function [7:0] hex;
      input [3:0] n;
      begin
         if (n < 4'hA)
            hex = 8'h30 + {4'h0, n};
         else
            hex = 8'h37 + {4'h0, n};
      end
   endfunction

   // CRC-8 CCITT, polynomial 07h, one byte
   function [7:0] crc8;
      input [7:0] c;
      input [7:0] d;
      integer     k;
      reg   [7:0] r;
      begin
         r = c ^ d;
         for (k = 0; k < 8; k = k + 1)
            r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
         crc8 = r;
      end
   endfunction

   // Byte i of an answer frame
   function [7:0] frame_byte;
      input       bin;
      input       err;
      input [15:0] p;
      input [15:0] v;
      input [3:0]  i;
      input [7:0]  c;
      begin
         frame_byte = `CH_LF;
         if (bin)
            case (i)
               4'h0: frame_byte = err ? `CH_ERROR : `CH_ANSWER;
               4'h1: frame_byte = p[15:8];
               4'h2: frame_byte = p[7:0];
               4'h3: frame_byte = v[15:8];
               4'h4: frame_byte = v[7:0];
               4'h5: frame_byte = `CH_CR;
               4'h6: frame_byte = c;
               default: frame_byte = `CH_LF;
            endcase
         else if (err)
            case (i)
               4'h0: frame_byte = `CH_ERROR;
               4'h1: frame_byte = hex(p[15:12]);
               4'h2: frame_byte = hex(p[11:8]);
               4'h3: frame_byte = hex(p[7:4]);
               4'h4: frame_byte = hex(p[3:0]);
               4'h5: frame_byte = `CH_CR;
               4'h6: frame_byte = hex(c[7:4]);
               4'h7: frame_byte = hex(c[3:0]);
               default: frame_byte = `CH_LF;
            endcase
         else
            case (i)
               4'h0: frame_byte = `CH_ANSWER;
               4'h1: frame_byte = hex(p[15:12]);
               4'h2: frame_byte = hex(p[11:8]);
               4'h3: frame_byte = hex(p[7:4]);
               4'h4: frame_byte = hex(p[3:0]);
               4'h5: frame_byte = `CH_SPACE;
               4'h6: frame_byte = hex(v[15:12]);
               4'h7: frame_byte = hex(v[11:8]);
               4'h8: frame_byte = hex(v[7:4]);
               4'h9: frame_byte = hex(v[3:0]);
               4'hA: frame_byte = `CH_CR;
               4'hB: frame_byte = hex(c[7:4]);
               4'hC: frame_byte = hex(c[3:0]);
               default: frame_byte = `CH_LF;
            endcase
      end
   endfunction

   reg        cs_stored;
   reg        echo_stored;
   reg        bin_mode;
   reg [2:0]  rate_pending;
   reg        last_was_start;
   reg [22:0] save_cnt;
   reg        saving;
   reg        state;
   reg        rsp_err;
   reg        rsp_set;
   reg        rsp_bin;
   reg [15:0] rsp_param;
   reg [15:0] rsp_val;
   reg [3:0]  idx;
   reg [3:0]  last_idx;
   reg [3:0]  body_len;
   reg [7:0]  crc;
   reg [2:0]  warn_sync;
   reg [2:0]  prot_sync;
   reg        warn_lvl;
   reg        prot_lvl;
   reg [15:0] rd_val;
   reg [15:0] next_val;
   reg        next_known;
   wire       take;
   wire       is_set;
   wire       is_get;
   wire       answer;
   wire [15:0] dur_max;
   wire [15:0] state_word;
   wire [15:0] lock_word;
   wire [7:0]  crc_next;
   wire [15:0] rd_sel;

   assign take = cmd_valid && cmd_ready;
   assign is_set = (cmd_type == `CH_SET);
   assign is_get = (cmd_type == `CH_GET);
   assign cmd_ready = (state == S_IDLE) && !saving;
   assign save_busy = saving;
   assign tx_valid = (state == S_SEND);
   assign binary_mode = bin_mode;
   assign checksum_on = cs_stored || bin_mode;
   assign dur_max = dur_limit(freq_value);
   assign continuous_output = (freq_value == 16'h0000);
   assign long_pulse_output = !continuous_output;
   assign state_word = {11'h000, enable_internal, 1'b0,
                        setpoint_internal, tec_started, 1'b1};
   // Both flags together mark the protection state
   assign lock_word = {11'h000, warn_lvl || prot_lvl, prot_lvl,
                       3'h0};
   // Bit 0 always one: the extended options are supported
   assign serial_link_options = {9'h000, bin_mode, baud_sel,
                                 echo_stored, cs_stored,
                                 1'b1};
   // Echo is forced on in binary; a silent set needs no answer
   assign answer = !is_set || echo_stored || bin_mode;
   assign crc_next = (idx < body_len) ? crc8(crc, tx_data) : crc;
   // While answering, the mux rereads the answered parameter
   assign rd_sel = (state == S_IDLE) ? cmd_param : rsp_param;

   // Pin inputs pass three flops; a change counts when 2 and 3 agree
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         warn_sync <= 3'h0;
         prot_sync <= 3'h0;
         warn_lvl  <= 1'b0;
         prot_lvl  <= 1'b0;
      end
      else
      begin
         warn_sync <= {warn_sync[1:0], overtemp_warn_pin};
         prot_sync <= {prot_sync[1:0], overtemp_prot_pin};
         if (warn_sync[1] == warn_sync[2])
            warn_lvl <= warn_sync[2];
         if (prot_sync[1] == prot_sync[2])
            prot_lvl <= prot_sync[2];
      end
   end

   // Read mux; unknown parameters answer with number and value zero
   always @*
   begin
      rd_val = 16'h0000;
      next_known = 1'b1;
      case (rd_sel)
         `P_FREQ:          rd_val = freq_value;
         `P_FREQ_MIN:      rd_val = `FREQ_MIN_V;
         `P_FREQ_MAX:      rd_val = `FREQ_MAX_V;
         `P_DUR:           rd_val = duration_value;
         `P_DUR_MIN:       rd_val = DUR_MIN;
         `P_DUR_MAX:       rd_val = dur_max;
         `P_LINK_OPTIONS:  rd_val = serial_link_options;
         `P_LOCK_STATUS:   rd_val = lock_word;
         `P_TEC_CUR_MEAS:  rd_val = tec_current_in;
         `P_TEC_CUR_LIM:   rd_val = tec_current_limit;
         `P_TEC_VOLT_MEAS: rd_val = tec_voltage_in;
         `P_TEC_STATE:     rd_val = state_word;
         `P_TEC_CAL:       rd_val = tec_calibration;
         `P_THERM_BETA:    rd_val = thermistor_beta;
         default:          next_known = 1'b0;
      endcase
      next_val = rd_val;
   end

   // Parameter writes with clamping and side effects
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         freq_value        <= `FREQ_MIN_V;
         duration_value    <= DUR_MIN;
         tec_current_limit <= `CUR_LIM_RESET;
         tec_calibration   <= `CAL_RESET;
         thermistor_beta   <= `BETA_RESET;
         tec_started       <= 1'b0;
         setpoint_internal <= 1'b1;
         enable_internal   <= 1'b1;
         cs_stored         <= 1'b0;
         echo_stored       <= 1'b0;
         bin_mode          <= 1'b0;
         rate_pending      <= `RATE_DEFAULT;
         last_was_start    <= 1'b0;
      end
      else
      begin
         // Duration follows the limit of the current frequency
         if (duration_value > dur_max)
            duration_value <= dur_max;
         if (take)
            last_was_start <= 1'b0;
         if (take && is_set)
            case (cmd_param)
               `P_FREQ:
                  freq_value <= clamp(cmd_value, `FREQ_MIN_V,
                                      `FREQ_MAX_V);
               `P_DUR:
                  duration_value <= clamp(cmd_value, DUR_MIN,
                                          dur_max);
               `P_TEC_CUR_LIM:
                  tec_current_limit <= clamp(cmd_value, 16'h0000,
                                             `CUR_LIM_MAX);
               `P_TEC_CAL:
                  tec_calibration <= clamp(cmd_value, `CAL_MIN,
                                           `CAL_MAX);
               `P_THERM_BETA:
                  thermistor_beta <= clamp(cmd_value, `BETA_MIN,
                                           `BETA_MAX);
               `P_TEC_STATE:
               begin
                  // Start only when enable is internal
                  if (cmd_value == `ST_START)
                  begin
                     tec_started <= enable_internal;
                     last_was_start <= enable_internal;
                  end
                  else
                     tec_started <= 1'b0;
                  if (cmd_value[`ST_SRC_INT_BIT])
                     setpoint_internal <= 1'b1;
                  if (cmd_value[`ST_SRC_EXT_BIT])
                     setpoint_internal <= 1'b0;
                  if (cmd_value[`ST_EN_INT_BIT])
                     enable_internal <= 1'b1;
                  if (cmd_value[`ST_EN_EXT_BIT])
                     enable_internal <= 1'b0;
               end
               `P_LINK_OPTIONS:
                  case (cmd_value)
                     `LK_CS_ON:   if (!bin_mode) cs_stored <= 1'b1;
                     `LK_CS_OFF:  if (!bin_mode) cs_stored <= 1'b0;
                     `LK_ECHO_ON: if (!bin_mode) echo_stored <= 1'b1;
                     `LK_ECHO_OFF:
                        if (!bin_mode)
                           echo_stored <= 1'b0;
                     `LK_RATE_2400:   rate_pending <= 3'h0;
                     `LK_RATE_9600:   rate_pending <= 3'h1;
                     `LK_RATE_10417:  rate_pending <= 3'h2;
                     `LK_RATE_57600:  rate_pending <= 3'h4;
                     `LK_RATE_115200: rate_pending <= 3'h5;
                     `LK_TEXT:   bin_mode <= 1'b0;
                     `LK_BINARY: bin_mode <= 1'b1;
                     default:    bin_mode <= bin_mode;
                  endcase
               default:
                  last_was_start <= 1'b0;
            endcase
      end
   end

   // Save timer: start then stop saves; input refused for 300 ms
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         saving     <= 1'b0;
         save_cnt   <= 23'h000000;
         save_start <= 1'b0;
      end
      else
      begin
         save_start <= 1'b0;
         if (take && is_set && cmd_param == `P_TEC_STATE &&
             cmd_value == `ST_STOP && last_was_start)
         begin
            saving     <= 1'b1;
            save_start <= 1'b1;
            save_cnt   <= 23'h000000;
         end
         else if (saving)
         begin
            if (save_cnt == SAVE_END[22:0])
               saving <= 1'b0;
            save_cnt <= save_cnt + 23'h000001;
         end
      end
   end

   // Answer framing; rate switches once the answer has left
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         state     <= S_IDLE;
         rsp_err   <= 1'b0;
         rsp_set   <= 1'b0;
         rsp_bin   <= 1'b0;
         rsp_param <= 16'h0000;
         rsp_val   <= 16'h0000;
         idx       <= 4'h0;
         last_idx  <= 4'h0;
         body_len  <= 4'h0;
         crc       <= 8'h00;
         tx_data   <= 8'h00;
         baud_sel  <= `RATE_DEFAULT;
      end
      else
         case (state)
            S_IDLE:
            begin
               if (!take || !answer)
                  baud_sel <= rate_pending;
               if (take && answer)
               begin
                  rsp_err   <= !(is_set || is_get);
                  rsp_set   <= is_set;
                  rsp_bin   <= bin_mode;
                  rsp_param <= (is_set || is_get) ?
                               (next_known ? cmd_param : 16'h0000) :
                               `ERR_UNKNOWN;
                  rsp_val   <= (is_set || is_get) ? next_val : 16'h0000;
                  idx       <= 4'h0;
                  crc       <= 8'h00;
                  state     <= S_SEND;
                  tx_data   <= bin_mode ? frame_byte(1'b1,
                               !(is_set || is_get), 16'h0000, 16'h0000,
                               4'h0, 8'h00) :
                               ((is_set || is_get) ? `CH_ANSWER :
                               `CH_ERROR);
                  if (bin_mode)
                  begin
                     body_len <= 4'h6;
                     last_idx <= 4'h7;
                  end
                  else if (!(is_set || is_get))
                  begin
                     body_len <= 4'h6;
                     last_idx <= cs_stored ? 4'h8 : 4'h5;
                  end
                  else
                  begin
                     body_len <= 4'hB;
                     last_idx <= cs_stored ? 4'hD : 4'hA;
                  end
               end
            end
            S_SEND:
            begin
               // Set answers carry the value after the write has landed
               if (rsp_set && idx == 4'h0)
                  rsp_val <= next_val;
               // Framing stays as it was when the command was taken
               if (tx_ready)
               begin
                  crc <= crc_next;
                  idx <= idx + 4'h1;
                  tx_data <= frame_byte(rsp_bin, rsp_err, rsp_param,
                                        rsp_val, idx + 4'h1, crc_next);
                  if (idx == last_idx)
                     state <= S_IDLE;
               end
            end
            default:
               state <= S_IDLE;
         endcase
   end

   // Set answers report the stored value, so they follow the clamp
   // one cycle late; rsp_val is refreshed after the write settles.
   // The tradeoff keeps the write path and the answer path apart.

endmodule // tec_param_core

// ===== src/tec_param_map.vh
// Parameter numbers, command codes, limits and timing for the TEC block
`ifndef TEC_PARAM_MAP_VH
`define TEC_PARAM_MAP_VH

// Parameter numbers
`define P_FREQ          16'h0100
`define P_FREQ_MIN      16'h0101
`define P_FREQ_MAX      16'h0102
`define P_DUR           16'h0200
`define P_DUR_MIN       16'h0201
`define P_DUR_MAX       16'h0202
`define P_LINK_OPTIONS  16'h0704
`define P_LOCK_STATUS   16'h0800
`define P_TEC_CUR_MEAS  16'h0A16
`define P_TEC_CUR_LIM   16'h0A17
`define P_TEC_VOLT_MEAS 16'h0A18
`define P_TEC_STATE     16'h0A1A
`define P_TEC_CAL       16'h0A1E
`define P_THERM_BETA    16'h0A1F

// Command type characters and framing bytes
`define CH_SET          8'h50
`define CH_GET          8'h4A
`define CH_ANSWER       8'h4B
`define CH_ERROR        8'h45
`define CH_SPACE        8'h20
`define CH_CR           8'h0D
`define CH_LF           8'h0A
`define ERR_UNKNOWN     16'h0001

// State control codes
`define ST_START        16'h0008
`define ST_STOP         16'h0010
`define ST_SRC_INT_BIT  5
`define ST_SRC_EXT_BIT  6
`define ST_EN_EXT_BIT   9
`define ST_EN_INT_BIT   10

// Link option write codes
`define LK_CS_ON        16'h0002
`define LK_CS_OFF       16'h0004
`define LK_ECHO_ON      16'h0008
`define LK_ECHO_OFF     16'h0010
`define LK_RATE_2400    16'h0100
`define LK_RATE_9600    16'h0120
`define LK_RATE_10417   16'h0140
`define LK_RATE_57600   16'h0180
`define LK_RATE_115200  16'h01A0
`define LK_TEXT         16'h0200
`define LK_BINARY       16'h0400
`define RATE_DEFAULT    3'h5

// Limits and reset values
`define CAL_RESET       16'h2710
`define CAL_MIN         16'h251C
`define CAL_MAX         16'h2904
`define FREQ_MIN_V      16'h0000
`define FREQ_MAX_V      16'h2710
`define CUR_LIM_MAX     16'h0050
`define CUR_LIM_RESET   16'h0020
`define BETA_MIN        16'h0BB8
`define BETA_MAX        16'h1388
`define BETA_RESET      16'h0F8C

// Timing: pulse rules in ms, parameter units of 0.1 ms and 0.1 Hz
`define DUR_MIN_MS      2
`define DUR_CAP_MS      5000
`define UNITS_PER_MS    10
`define PERIOD_NUM      100000
`define SAVE_MS         300
`define CLK_HZ          25000000

`endif

// ===== verification/tec_param_checker.sv
// Port checker for the TEC parameter core
`timescale 1ns/1ps
module tec_param_checker
#(
   parameter SAVE_CYCLES = 20
)
(
   input wire        clk,
   input wire        sys_rst,
   input wire        cmd_ready,
   input wire        tx_valid,
   input wire        tx_ready,
   input wire [7:0]  tx_data,
   input wire        continuous_output,
   input wire        long_pulse_output,
   input wire [15:0] freq_value,
   input wire [15:0] duration_value,
   input wire [15:0] tec_calibration,
   input wire [15:0] serial_link_options,
   input wire        binary_mode,
   input wire        save_start,
   input wire        save_busy
);
   reg [31:0] busy_n;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Length of the running save, so a stuck busy shows up
   always @(posedge clk)
      busy_n <= (sys_rst || !save_busy) ? 32'h0 : busy_n + 32'h1;
   a_busy_refuse: assert property (save_busy |-> !cmd_ready)
      else $error("command accepted while saving");
   a_save_follow: assert property (save_start |=> save_busy)
      else $error("save did not start");
   a_busy_bound: assert property (busy_n <= SAVE_CYCLES)
      else $error("save lasted too long");
   a_send_block: assert property (tx_valid |-> !cmd_ready)
      else $error("command accepted while answering");
   a_tx_hold: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_data)) else $error("answer byte moved");
   a_mode_excl: assert property (
      long_pulse_output != continuous_output
      && continuous_output == (freq_value == 16'h0000))
      else $error("output mode wrong");
   a_dur_window: assert property (
      duration_value >= 16'h0014
      && duration_value <= 16'hC350) else $error("duration out of range");
   a_cal_range: assert property (tec_calibration >= 16'h251C
      && tec_calibration <= 16'h2904) else $error("calibration out of range");
   a_opt_layout: assert property (serial_link_options[0]
      && serial_link_options[6] == binary_mode)
      else $error("options word layout wrong");
   // Main scenarios reached
   c_save: cover property (save_start);
   c_bin: cover property (binary_mode && tx_valid && tx_ready);
   c_stall: cover property (tx_valid && !tx_ready);
endmodule // tec_param_checker
bind tec_param_core tec_param_checker #(.SAVE_CYCLES(SAVE_CYCLES))
   u_tec_param_checker (.*);

// ===== verification/tec_host_model.sv
// Host-side answer sink with random stalls
`timescale 1ns/1ps
module tec_host_model
(
   input  wire clk,
   input  wire sys_rst,
   input  wire slow,
   output reg  tx_ready
);
   // Slow mode takes about one byte in four, prompt mode three in four
   initial tx_ready = 1'b0;
   always @(posedge clk)
      #1 tx_ready <= !sys_rst && (($urandom % 4 == 0) ^ !slow);
endmodule // tec_host_model

// ===== verification/tec_param_and_serial_protocol_cfg_bench.sv
// Self-checking bench for the TEC parameter and link options core
`timescale 1ns/1ps
`include "tec_param_map.vh"
module tec_param_and_serial_protocol_cfg_bench;
   logic        clk, sys_rst, cmd_valid, slow;
   logic        overtemp_warn_pin, overtemp_prot_pin;
   logic [7:0]  cmd_type;
   logic [15:0] cmd_param, cmd_value, tec_current_in, tec_voltage_in, v;
   wire         cmd_ready, tx_valid, tx_ready, tec_started, save_start;
   wire         setpoint_internal, enable_internal, continuous_output;
   wire         long_pulse_output, binary_mode, checksum_on, save_busy;
   wire  [7:0]  tx_data;
   wire  [2:0]  baud_sel;
   wire  [15:0] freq_value, duration_value, tec_current_limit;
   wire  [15:0] tec_calibration, thermistor_beta, serial_link_options;
   logic [7:0]  expq[$];
   logic [7:0]  crc;
   int          n_errors, num_checks, cyc;
   logic [15:0] rc [5] = '{16'h0100, 16'h0120, 16'h0140, 16'h0180, 16'h01A0};
   logic [2:0]  rs [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
   localparam [47:0] ERR = {"E0001", 8'h0D};
   tec_param_core #(.SAVE_CYCLES(20)) u_tec_param_core
   (
      .clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_type, .cmd_param,
      .cmd_value, .tx_valid, .tx_ready, .tx_data, .tec_current_in,
      .tec_voltage_in, .overtemp_warn_pin, .overtemp_prot_pin,
      .tec_started, .setpoint_internal, .enable_internal,
      .continuous_output, .long_pulse_output, .freq_value,
      .duration_value, .tec_current_limit, .tec_calibration,
      .thermistor_beta, .serial_link_options, .baud_sel, .binary_mode,
      .checksum_on, .save_start, .save_busy
   );
   tec_host_model u_tec_host_model (.clk, .sys_rst, .slow, .tx_ready);
   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task chk(input string nm, input [15:0] e, g);
      num_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   function [7:0] hx(input [3:0] d);
      return d > 9 ? 8'h37 + d : 8'h30 + d;
   endfunction
   // Notes one answer byte and folds it into the CRC-8, poly 07h
   task put(input [7:0] d);
      expq.push_back(d);
      crc ^= d;
      repeat (8) crc = {crc[6:0], 1'b0} ^ (crc[7] ? 8'h07 : 8'h00);
   endtask
   // Text answer: K, parameter digits, space, value digits, CR[, CRC, LF]
   task exp_k(input [15:0] p, v, input bit cs = 1'b0);
      crc = 8'h00;
      put(`CH_ANSWER);
      for (int i = 12; i >= 0; i -= 4) put(hx(p[i+:4]));
      put(`CH_SPACE);
      for (int i = 12; i >= 0; i -= 4) put(hx(v[i+:4]));
      put(`CH_CR);
      if (cs)
      begin
         expq.push_back(hx(crc[7:4]));
         expq.push_back(hx(crc[3:0]));
         expq.push_back(`CH_LF);
      end
   endtask
   // Binary answer with CRC-8 seeded 00h
   task exp_b(input [15:0] p, v);
      crc = 8'h00;
      put(`CH_ANSWER);
      put(p[15:8]);
      put(p[7:0]);
      put(v[15:8]);
      put(v[7:0]);
      put(`CH_CR);
      expq.push_back(crc);
      expq.push_back(`CH_LF);
   endtask
   // Holds the command until an edge that samples ready high
   task send(input [15:0] p, v, input [7:0] t = `CH_SET);
      {cmd_valid, cmd_type, cmd_param, cmd_value} = {1'b1, t, p, v};
      while (cmd_ready !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1 cmd_valid = 1'b0;
      repeat (2) @(posedge clk) #1;
   endtask
   task idle;
      while (expq.size() || cmd_ready !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1; // Let the idle cycle apply a pending rate
   endtask
   task finish_test(input bit hang);
      n_errors += hang;
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Each accepted answer byte is matched against the oldest note
   always @(posedge clk)
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         chk("tx_data", expq.size() ? expq.pop_front() : 8'hXX, tx_data);
   // Hang guard
   always @(posedge clk)
      if (++cyc == 30000)
         finish_test(1);
   initial
   begin
      {sys_rst, cmd_valid, cmd_type, cmd_param, cmd_value} = 42'h200_0000_0000;
      {slow, overtemp_prot_pin, overtemp_warn_pin} = 3'b000;
      void'($urandom(79524));
      tec_current_in = 16'($urandom);
      tec_voltage_in = 16'($urandom);
      repeat (16) @(posedge clk);
      #1 sys_rst = 1'b0;
      exp_k(`P_TEC_CAL, `CAL_RESET);
      send(`P_TEC_CAL, 0, `CH_GET);
      chk("options", 16'h0029, serial_link_options);
      for (int i = 0; i < 3; i++)
      begin
         v = i ? 16'hFFFF : 16'h0000;
         if (i == 2) v = `CAL_MIN + 16'($urandom % 1001);
         send(`P_TEC_CAL, v);
         chk("calibration", i == 2 ? v : i ? 16'h2904 : 16'h251C,
             tec_calibration);
      end
      send(`P_FREQ, 0);
      chk("continuous", 1, continuous_output);
      send(`P_FREQ, 1);
      send(`P_DUR, 16'hFFFF);
      chk("long pulse", 1, long_pulse_output);
      chk("duration", `DUR_CAP_MS * `UNITS_PER_MS, duration_value);
      send(`P_DUR, 0);
      chk("duration", `DUR_MIN_MS * `UNITS_PER_MS, duration_value);
      send(`P_DUR, 16'hFFFF);
      send(`P_FREQ, 16'd1000);
      chk("duration", `PERIOD_NUM / 1000 - 20, duration_value);
      exp_k(`P_TEC_CUR_MEAS, tec_current_in);
      send(`P_TEC_CUR_MEAS, 0, `CH_GET);
      send(`P_THERM_BETA, 0);
      chk("beta", `BETA_MIN, thermistor_beta);
      send(`P_TEC_CUR_LIM, 16'hFFFF);
      chk("current limit", `CUR_LIM_MAX, tec_current_limit);
      for (int i = 0; i < 2; i++)
      begin
         {overtemp_prot_pin, overtemp_warn_pin} = i ? 2'b10 : 2'b01;
         slow = i;
         repeat (6) @(posedge clk) #1;
         exp_k(`P_LOCK_STATUS, i ? 16'h0018 : 16'h0010);
         send(`P_LOCK_STATUS, 0, `CH_GET);
      end
      send(`P_TEC_STATE, `ST_START);
      chk("started", 1, tec_started);
      send(`P_TEC_STATE, `ST_STOP);
      chk("started", 0, tec_started);
      chk("save busy", 1, save_busy);
      send(`P_TEC_STATE, `ST_START);
      send(`P_TEC_STATE, 16'h0200);
      chk("started", 0, tec_started);
      chk("save busy", 0, save_busy);
      chk("enable int", 0, enable_internal);
      send(`P_TEC_STATE, `ST_START);
      chk("started", 0, tec_started);
      send(`P_TEC_STATE, 16'h0440);
      chk("enable int", 1, enable_internal);
      chk("setpoint int", 0, setpoint_internal);
      send(`P_TEC_STATE, 16'h0020);
      chk("setpoint int", 1, setpoint_internal);
      for (int i = 0; i < 5; i++)
      begin
         send(`P_LINK_OPTIONS, rc[i]);
         chk("baud", rs[i], baud_sel);
      end
      send(`P_LINK_OPTIONS, `LK_CS_ON);
      chk("checksum", 1, checksum_on);
      send(`P_LINK_OPTIONS, `LK_CS_OFF);
      chk("checksum", 0, checksum_on);
      send(`P_LINK_OPTIONS, `LK_BINARY);
      chk("checksum", 1, checksum_on);
      // Answers keep binary framing; the last echoes the text-mode word
      for (int i = 0; i < 3; i++)
         exp_b(`P_LINK_OPTIONS, i == 2 ? 16'h0029 : 16'h0069);
      send(`P_LINK_OPTIONS, `LK_CS_ON);
      send(`P_LINK_OPTIONS, 0, `CH_GET);
      send(`P_LINK_OPTIONS, `LK_TEXT);
      idle;
      chk("binary", 0, binary_mode);
      send(`P_LINK_OPTIONS, `LK_ECHO_ON);
      exp_k(`P_LINK_OPTIONS, 16'h002D);
      send(`P_LINK_OPTIONS, `LK_RATE_2400);
      chk("baud", 5, baud_sel);
      idle;
      chk("baud", 0, baud_sel);
      for (int k = 5; k >= 0; k--) expq.push_back(ERR[k*8+:8]);
      send(16'h0000, 0, 8'h41);
      idle;
      exp_k(`P_LINK_OPTIONS, 16'h0007);
      send(`P_LINK_OPTIONS, `LK_CS_ON);
      exp_k(`P_TEC_CAL, v, 1'b1);
      send(`P_TEC_CAL, 0, `CH_GET);
      idle;
      finish_test(0);
   end
endmodule // tec_param_and_serial_protocol_cfg_bench
